// File: rtl/incl_ctrl_pkg.sv
// How it works
// - Read command word; reply in next transfer
// - Bit 15 flags unread sample
// - Bit 14 flags nonzero status word
// - Supply reading unsigned, 0.30518 mV per count
// - Auxiliary reading unsigned 12 bits, 13:12 zero
// - Period is base times multiplier plus offset
// - Below 546 samples/s use reduced power
// - Sleep for count times half a second
// - Sleep runs to completion, reset excepted
// - Average 2^M samples, M at most 8
// - Data-ready has top priority on lines
// - Enable, polarity and line select bits
// - Data-ready asserted a quarter of period
// - Misc bit 8 applies self-test stimulus
// - Misc bit 10 set skips power-on test
package incl_ctrl_pkg;

   // Register addresses (upper byte of a command word)
   localparam logic [6:0] ADDR_SUPPLY   = 7'h02;
   localparam logic [6:0] ADDR_AUX      = 7'h08;
   localparam logic [6:0] ADDR_MISC     = 7'h34;
   localparam logic [6:0] ADDR_SAMPLE   = 7'h36;
   localparam logic [6:0] ADDR_AVERAGE  = 7'h38;
   localparam logic [6:0] ADDR_SLEEP    = 7'h3A;

   // Values after reset, and the largest averaging exponent
   localparam logic [7:0]  SAMPLE_RESET  = 8'h14;
   localparam logic [7:0]  SLEEP_RESET   = 8'h00;
   localparam logic [3:0]  AVERAGE_RESET = 4'h8;
   localparam logic [3:0]  AVERAGE_MAX   = 4'h8;

   // Field positions
   localparam int WRITE_BIT      = 15;
   localparam int NEW_DATA_BIT   = 15;
   localparam int ERROR_BIT      = 14;
   localparam int TIMEBASE_BIT   = 7;
   localparam int MISC_SELFTEST  = 8;
   localparam int MISC_POST_OFF  = 10;
   localparam int MISC_DR_EN     = 2;
   localparam int MISC_DR_POL    = 1;
   localparam int MISC_DR_SEL    = 0;

   // Times and their cycle counts at the system clock
   localparam real CLK_MHZ        = 125.0;
   localparam real BASE_SHORT_US  = 244.14;
   localparam real BASE_LONG_MS   = 7.568;
   localparam real OFFSET_US      = 122.07;
   localparam real SLEEP_UNIT_S   = 0.5;
   localparam real LOW_POWER_US   = 1831.502;
   localparam int  BASE_SHORT_CYC = int'(BASE_SHORT_US * CLK_MHZ);
   localparam int  BASE_LONG_CYC  = int'(BASE_LONG_MS * 1000.0 * CLK_MHZ);
   localparam int  OFFSET_CYC     = int'(OFFSET_US * CLK_MHZ);
   localparam int  SLEEP_UNIT_CYC = int'(SLEEP_UNIT_S * 1000000.0 * CLK_MHZ);
   localparam int  LOW_POWER_CYC  = int'(LOW_POWER_US * CLK_MHZ);

endpackage : incl_ctrl_pkg

// File: rtl/spi_link.sv
`timescale 1ns/1ps
// Serial clock domain: mode 3, 16-bit frames, MSB first.
module spi_link (
   // System side
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] tx_word_i,
   output logic      [15:0] rx_word_o,
   output logic             rx_valid_o,
   // Link pins
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   output logic             dout_o
);
   logic [3:0]  bit_cnt;
   logic [14:0] shift;
   logic [15:0] rx_hold;
   logic        cs_meta;
   logic        cs_sync;
   logic        cs_last;
   logic        frame_end;

   // Counter idles at zero between frames
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt <= 4'h0;
         shift   <= 15'h0000;
      end else begin
         bit_cnt <= bit_cnt + 4'h1;
         shift   <= {shift[13:0], din_i};
      end
   end

   // Held after the frame so the system side can pick it up
   always_ff @(posedge sclk_i) begin
      if (!cs_n_i && bit_cnt == 4'hF) begin
         rx_hold <= {shift, din_i};
      end
   end

   // tx_word_i only moves between frames, so it is stable here;
   // the first falling edge of a frame already presents bit 15
   always_ff @(negedge sclk_i) begin
      dout_o <= tx_word_i[4'hF - bit_cnt];
   end

   // Frame end seen in the system domain through two flops
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_last <= 1'b1;
      end else begin
         cs_meta <= cs_n_i;
         cs_sync <= cs_meta;
         cs_last <= cs_sync;
      end
   end

   assign frame_end = cs_sync && !cs_last;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_word_o  <= 16'h0000;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= frame_end;
         if (frame_end) begin
            rx_word_o <= rx_hold;
         end
      end
   end

endmodule : spi_link

// File: rtl/sample_timer.sv
`timescale 1ns/1ps
module sample_timer #(
   parameter int BASE_SHORT_CYC = incl_ctrl_pkg::BASE_SHORT_CYC,
   parameter int BASE_LONG_CYC  = incl_ctrl_pkg::BASE_LONG_CYC,
   parameter int OFFSET_CYC     = incl_ctrl_pkg::OFFSET_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Control
   input  wire logic        run_i,
   input  wire logic        base_long_i,
   input  wire logic [6:0]  mult_i,
   // Timing
   output logic             tick_o,
   output logic             quarter_o,
   output logic      [31:0] period_o
);
   logic [31:0] count;
   logic [31:0] base;
   logic        last;

   assign base     = base_long_i ? 32'(BASE_LONG_CYC) : 32'(BASE_SHORT_CYC);
   assign period_o = 32'(base * {25'h0000000, mult_i}) + 32'(OFFSET_CYC);
   assign last     = count >= period_o - 32'h1;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !run_i) begin
         count     <= 32'h0;
         tick_o    <= 1'b0;
         quarter_o <= 1'b0;
      end else begin
         count     <= last ? 32'h0 : count + 32'h1;
         tick_o    <= last;
         quarter_o <= last || (count + 32'h1 < (period_o >> 2));
      end
   end

endmodule : sample_timer

// File: rtl/incl_ctrl.sv
`timescale 1ns/1ps
module incl_ctrl #(
   parameter int BASE_SHORT_CYC = incl_ctrl_pkg::BASE_SHORT_CYC,
   parameter int BASE_LONG_CYC  = incl_ctrl_pkg::BASE_LONG_CYC,
   parameter int OFFSET_CYC     = incl_ctrl_pkg::OFFSET_CYC,
   parameter int SLEEP_UNIT_CYC = incl_ctrl_pkg::SLEEP_UNIT_CYC,
   parameter int LOW_POWER_CYC  = incl_ctrl_pkg::LOW_POWER_CYC
) (
   // System
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Serial link
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   output logic             dout_o,
   // Converter results and status
   input  wire logic [13:0] supply_sample_i,
   input  wire logic [11:0] aux_sample_i,
   input  wire logic        status_nonzero_i,
   // Sensor controls
   output logic             sample_strobe_o,
   output logic             low_power_o,
   output logic      [3:0]  avg_log2_o,
   output logic             sleep_o,
   output logic             self_test_o,
   output logic             power_on_test_en_o,
   // Digital I/O lines
   output logic             io_line_one_o,
   output logic             io_line_one_oe_o,
   output logic             io_line_two_o,
   output logic             io_line_two_oe_o
);
   logic [15:0] tx_word;
   logic [15:0] rx_word;
   logic        rx_valid;
   logic [7:0]  sample_period_config;
   logic [7:0]  sleep_duration;
   logic [3:0]  averaging_depth;
   logic [10:0] misc_io_selftest_control;
   logic [13:0] supply_voltage_reading;
   logic [11:0] auxiliary_input_reading;
   logic        supply_new;
   logic        aux_new;
   logic        sleeping;
   logic [7:0]  sleep_left;
   logic [31:0] sleep_unit;
   logic        tick;
   logic        quarter;
   logic [31:0] period;

   function automatic logic [3:0] clamp_avg(input logic [3:0] m);
      clamp_avg = (m > incl_ctrl_pkg::AVERAGE_MAX) ? incl_ctrl_pkg::AVERAGE_MAX : m;
   endfunction : clamp_avg

   spi_link u_link (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .tx_word_i  (tx_word),
      .rx_word_o  (rx_word),
      .rx_valid_o (rx_valid),
      .sclk_i     (sclk_i),
      .cs_n_i     (cs_n_i),
      .din_i      (din_i),
      .dout_o     (dout_o)
   );

   sample_timer #(
      .BASE_SHORT_CYC (BASE_SHORT_CYC),
      .BASE_LONG_CYC  (BASE_LONG_CYC),
      .OFFSET_CYC     (OFFSET_CYC)
   ) u_timer (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .run_i       (!sleeping),
      .base_long_i (sample_period_config[incl_ctrl_pkg::TIMEBASE_BIT]),
      .mult_i      (sample_period_config[6:0]),
      .tick_o      (tick),
      .quarter_o   (quarter),
      .period_o    (period)
   );

   // Command decode
   wire       is_write   = rx_valid && rx_word[incl_ctrl_pkg::WRITE_BIT];
   wire       is_read    = rx_valid && !rx_word[incl_ctrl_pkg::WRITE_BIT];
   wire [6:0] cmd_addr   = rx_word[14:8];
   wire [6:0] word_addr  = {cmd_addr[6:1], 1'b0};
   wire       hi_byte    = cmd_addr[0];
   wire [7:0] wr_data    = rx_word[7:0];
   wire       wr_sample  = is_write && word_addr == incl_ctrl_pkg::ADDR_SAMPLE && !hi_byte;
   wire       wr_sleep   = is_write && word_addr == incl_ctrl_pkg::ADDR_SLEEP && !hi_byte;
   wire       wr_average = is_write && word_addr == incl_ctrl_pkg::ADDR_AVERAGE && !hi_byte;
   wire       wr_misc_lo = is_write && word_addr == incl_ctrl_pkg::ADDR_MISC && !hi_byte;
   wire       wr_misc_hi = is_write && word_addr == incl_ctrl_pkg::ADDR_MISC && hi_byte;
   wire       rd_supply  = is_read && word_addr == incl_ctrl_pkg::ADDR_SUPPLY;
   wire       rd_aux     = is_read && word_addr == incl_ctrl_pkg::ADDR_AUX;
   wire       update     = tick && !sleeping;

   // unread flag, error flag, supply format
   wire [15:0] supply_word = {supply_new, status_nonzero_i, supply_voltage_reading};
   // auxiliary format with unused bits zero
   wire [15:0] aux_word    = {aux_new, status_nonzero_i, 2'b00, auxiliary_input_reading};

   wire [15:0] read_word =
      (word_addr == incl_ctrl_pkg::ADDR_SUPPLY)  ? supply_word :
      (word_addr == incl_ctrl_pkg::ADDR_AUX)     ? aux_word :
      (word_addr == incl_ctrl_pkg::ADDR_SAMPLE)  ? {8'h00, sample_period_config} :
      (word_addr == incl_ctrl_pkg::ADDR_SLEEP)   ? {8'h00, sleep_duration} :
      (word_addr == incl_ctrl_pkg::ADDR_AVERAGE) ? {12'h000, averaging_depth} :
      (word_addr == incl_ctrl_pkg::ADDR_MISC)    ? {5'h00, misc_io_selftest_control} :
      16'h0000;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_word <= 16'h0000;
      end else if (is_read) begin
         tx_word <= read_word;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sample_period_config     <= incl_ctrl_pkg::SAMPLE_RESET;
         averaging_depth          <= incl_ctrl_pkg::AVERAGE_RESET;
         misc_io_selftest_control <= 11'h000;
      end else begin
         if (wr_sample) begin
            sample_period_config <= wr_data;
         end
         if (wr_average) begin
            averaging_depth <= clamp_avg(wr_data[3:0]);
         end
         if (wr_misc_lo) begin
            misc_io_selftest_control[2:0] <= wr_data[2:0];
         end
         if (wr_misc_hi) begin
            misc_io_selftest_control[10] <= wr_data[2];
            misc_io_selftest_control[8]  <= wr_data[0];
         end
      end
   end

   // Measurements latch once per sample period
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         supply_voltage_reading  <= 14'h0000;
         auxiliary_input_reading <= 12'h000;
         supply_new              <= 1'b0;
         aux_new                 <= 1'b0;
      end else begin
         if (update) begin
            supply_voltage_reading  <= supply_sample_i;
            auxiliary_input_reading <= aux_sample_i;
         end
         supply_new <= update || (supply_new && !rd_supply);
         aux_new    <= update || (aux_new && !rd_aux);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sleep_duration <= incl_ctrl_pkg::SLEEP_RESET;
         sleeping       <= 1'b0;
         sleep_left     <= 8'h00;
         sleep_unit     <= 32'h0;
      end else if (sleeping) begin
         if (sleep_unit >= 32'(SLEEP_UNIT_CYC) - 32'h1) begin
            sleep_unit <= 32'h0;
            sleep_left <= sleep_left - 8'h01;
            sleeping   <= sleep_left != 8'h01;
         end else begin
            sleep_unit <= sleep_unit + 32'h1;
         end
      end else if (wr_sleep) begin
         sleep_duration <= wr_data;
         sleep_left     <= wr_data;
         sleep_unit     <= 32'h0;
         sleeping       <= wr_data != 8'h00;
      end
   end

   // Data-ready routing, polarity and enable
   wire dr_en  = misc_io_selftest_control[incl_ctrl_pkg::MISC_DR_EN];
   wire dr_pol = misc_io_selftest_control[incl_ctrl_pkg::MISC_DR_POL];
   wire dr_sel = misc_io_selftest_control[incl_ctrl_pkg::MISC_DR_SEL];
   wire dr_lvl = dr_pol ? quarter : !quarter;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         io_line_one_o      <= 1'b0;
         io_line_one_oe_o   <= 1'b0;
         io_line_two_o      <= 1'b0;
         io_line_two_oe_o   <= 1'b0;
         sample_strobe_o    <= 1'b0;
         low_power_o        <= 1'b0;
         avg_log2_o         <= incl_ctrl_pkg::AVERAGE_RESET;
         sleep_o            <= 1'b0;
         self_test_o        <= 1'b0;
         power_on_test_en_o <= 1'b1;
      end else begin
         io_line_one_oe_o   <= dr_en && !dr_sel;
         io_line_two_oe_o   <= dr_en && dr_sel;
         io_line_one_o      <= dr_en && !dr_sel && dr_lvl;
         io_line_two_o      <= dr_en && dr_sel && dr_lvl;
         sample_strobe_o    <= update;
         low_power_o        <= period > 32'(LOW_POWER_CYC);
         avg_log2_o         <= averaging_depth;
         sleep_o            <= sleeping;
         self_test_o        <= misc_io_selftest_control[incl_ctrl_pkg::MISC_SELFTEST];
         power_on_test_en_o <= !misc_io_selftest_control[incl_ctrl_pkg::MISC_POST_OFF];
      end
   end

endmodule : incl_ctrl

// File: tb/incl_ctrl_assertions.sv
`timescale 1ns/1ps
module incl_ctrl_assertions #(
   parameter int SLEEP_UNIT_CYC = 100
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        sclk_i,
   input wire logic        cs_n_i,
   input wire logic        din_i,
   input wire logic        dout_o,
   input wire logic [13:0] supply_sample_i,
   input wire logic [11:0] aux_sample_i,
   input wire logic        status_nonzero_i,
   input wire logic        sample_strobe_o,
   input wire logic        low_power_o,
   input wire logic [3:0]  avg_log2_o,
   input wire logic        sleep_o,
   input wire logic        self_test_o,
   input wire logic        power_on_test_en_o,
   input wire logic        io_line_one_o,
   input wire logic        io_line_one_oe_o,
   input wire logic        io_line_two_o,
   input wire logic        io_line_two_oe_o
);
   logic [31:0] sleep_cycles;

   // Length of the current sleep, so its end can be checked
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) sleep_cycles <= 32'h0;
      else sleep_cycles <= sleep_o ? sleep_cycles + 32'h1 : 32'h0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   reset_values_a: assert property ($rose(rst_n_i) |-> avg_log2_o == 4'h8
      && power_on_test_en_o && !self_test_o && !sleep_o && !io_line_one_oe_o
      && !io_line_two_oe_o) else $error("outputs not at reset values");
   avg_max_a: assert property (avg_log2_o <= 4'h8)
      else $error("averaging exponent above 8");
   strobe_pulse_a: assert property (sample_strobe_o |=> !sample_strobe_o)
      else $error("sample strobe longer than one cycle");
   sleep_quiet_a: assert property ($past(sleep_o, 3) && sleep_o |-> !sample_strobe_o)
      else $error("sample taken during sleep");
   sleep_len_a: assert property ($fell(sleep_o) && $past(rst_n_i) |->
      sleep_cycles != 0 && sleep_cycles % SLEEP_UNIT_CYC == 0) else $error("sleep length wrong");
   oe_exclusive_a: assert property (!(io_line_one_oe_o && io_line_two_oe_o))
      else $error("both lines driven");
   cfg_on_frame_a: assert property ($past(rst_n_i) && ($changed(self_test_o)
      || $changed(power_on_test_en_o) || $changed(avg_log2_o)) |-> cs_n_i
      && $past(cs_n_i, 2)) else $error("control changed without a frame");
   oe_on_frame_a: assert property ($past(rst_n_i)
      && $changed({io_line_one_oe_o, io_line_two_oe_o}) |-> cs_n_i && $past(cs_n_i, 2))
      else $error("line enable changed without a frame");

   cover property (sample_strobe_o);
   cover property ($rose(sleep_o));
   cover property (io_line_two_oe_o && !io_line_two_o);
endmodule : incl_ctrl_assertions

bind incl_ctrl incl_ctrl_assertions #(.SLEEP_UNIT_CYC(SLEEP_UNIT_CYC)) i_incl_ctrl_assertions (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i),
   .dout_o(dout_o), .supply_sample_i(supply_sample_i), .aux_sample_i(aux_sample_i),
   .status_nonzero_i(status_nonzero_i), .sample_strobe_o(sample_strobe_o),
   .low_power_o(low_power_o), .avg_log2_o(avg_log2_o), .sleep_o(sleep_o),
   .self_test_o(self_test_o), .power_on_test_en_o(power_on_test_en_o),
   .io_line_one_o(io_line_one_o), .io_line_one_oe_o(io_line_one_oe_o),
   .io_line_two_o(io_line_two_o), .io_line_two_oe_o(io_line_two_oe_o));

// File: tb/spi_host.sv
`timescale 1ns/1ps
module spi_host (
   // Link pins
   output logic           sclk_o,
   output logic           cs_n_o,
   output logic           din_o,
   input  wire logic      dout_i
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o = 1'b1;
   end

   // 32 ns serial clock, sample periods scaled to match
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_n_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         #16 sclk_o = 1'b0;
         din_o = tx[i];
         #16 sclk_o = 1'b1;
         rx[i] = dout_i;
      end
      #16 cs_n_o = 1'b1;
      // Released line must not keep the last bit
      din_o = ~din_o;
      #64;
   endtask : xfer
endmodule : spi_host

// File: tb/incl_ctrl_tb.sv
`timescale 1ns/1ps
module incl_ctrl_tb;
   logic        clk_i;
   logic        rst_n_i;
   logic        sclk, cs_n, din, dout;
   logic [13:0] supply_sample_i;
   logic [11:0] aux_sample_i;
   logic        status_nonzero_i, sample_strobe_o, low_power_o, sleep_o;
   logic        self_test_o, power_on_test_en_o;
   logic [3:0]  avg_log2_o;
   logic        io_line_one_o, io_line_one_oe_o, io_line_two_o, io_line_two_oe_o;
   logic [15:0] rx, v;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          slp_n = 0;

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Small counts keep the run short: periods are N*20+10 or N*60+10
   incl_ctrl #(.BASE_SHORT_CYC(20), .BASE_LONG_CYC(60), .OFFSET_CYC(10),
      .SLEEP_UNIT_CYC(100), .LOW_POWER_CYC(150)) i_incl_ctrl (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
      .dout_o(dout), .supply_sample_i(supply_sample_i), .aux_sample_i(aux_sample_i),
      .status_nonzero_i(status_nonzero_i), .sample_strobe_o(sample_strobe_o),
      .low_power_o(low_power_o), .avg_log2_o(avg_log2_o), .sleep_o(sleep_o),
      .self_test_o(self_test_o), .power_on_test_en_o(power_on_test_en_o),
      .io_line_one_o(io_line_one_o), .io_line_one_oe_o(io_line_one_oe_o),
      .io_line_two_o(io_line_two_o), .io_line_two_oe_o(io_line_two_oe_o));
   spi_host i_spi_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

   always @(negedge clk_i) if (sleep_o === 1'b1) slp_n++;

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic frame(input logic [15:0] tx, output logic [15:0] r);
      @(negedge clk_i);
      i_spi_host.xfer(tx, r);
      repeat (8) @(negedge clk_i);
   endtask : frame

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      frame({1'b1, a, d}, rx);
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [15:0] r);
      frame({1'b0, a, 8'h00}, rx);
      frame(16'h0000, r);
   endtask : rd

   task automatic wait_strobe(output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (sample_strobe_o !== 1'b1 && n < 3000);
      check("sample_strobe_o", 16'h0001, 16'(sample_strobe_o));
   endtask : wait_strobe

   task automatic t_reset;
      logic [6:0]  ra [4];
      logic [15:0] rv [4];
      ra = '{incl_ctrl_pkg::ADDR_SAMPLE, incl_ctrl_pkg::ADDR_AVERAGE,
         incl_ctrl_pkg::ADDR_SLEEP, incl_ctrl_pkg::ADDR_MISC};
      rv = '{16'h0014, 16'h0008, 16'h0000, 16'h0000};
      // Registered outputs follow the configuration one edge after release
      repeat (2) @(negedge clk_i);
      check("avg_log2_o", 16'h0008, 16'(avg_log2_o));
      check("power_on_test_en_o", 16'h0001, 16'(power_on_test_en_o));
      check("low_power_o", 16'h0001, 16'(low_power_o));
      for (int i = 0; i < 4; i++) begin
         rd(ra[i], v);
         check("register reset value", rv[i], v);
      end
   endtask : t_reset

   task automatic t_period;
      int n;
      wr(incl_ctrl_pkg::ADDR_SAMPLE, 8'h01);
      wait_strobe(n);
      wait_strobe(n);
      check("short period", 16'h001E, 16'(n));
      check("low_power_o fast", 16'h0000, 16'(low_power_o));
      wr(incl_ctrl_pkg::ADDR_SAMPLE, 8'h83);
      wait_strobe(n);
      wait_strobe(n);
      check("long period", 16'h00BE, 16'(n));
      check("low_power_o slow", 16'h0001, 16'(low_power_o));
   endtask : t_period

   task automatic t_read;
      int n;
      wr(incl_ctrl_pkg::ADDR_SAMPLE, 8'h94);
      @(negedge clk_i);
      supply_sample_i = 14'h2A3D;
      aux_sample_i = 12'hFFF;
      wait_strobe(n);
      rd(incl_ctrl_pkg::ADDR_SUPPLY, v);
      check("supply unread", 16'hAA3D, v);
      rd(incl_ctrl_pkg::ADDR_SUPPLY, v);
      check("supply read again", 16'h2A3D, v);
      rd(incl_ctrl_pkg::ADDR_AUX, v);
      check("aux unread", 16'h8FFF, v);
      status_nonzero_i = 1'b1;
      rd(incl_ctrl_pkg::ADDR_AUX, v);
      check("aux with status", 16'h4FFF, v);
      status_nonzero_i = 1'b0;
      rd(7'h7E, v);
      check("unmapped read", 16'h0000, v);
      wr(incl_ctrl_pkg::ADDR_SAMPLE, 8'h01);
   endtask : t_read

   task automatic t_avg;
      wr(incl_ctrl_pkg::ADDR_AVERAGE, 8'h0F);
      check("avg clamp", 16'h0008, 16'(avg_log2_o));
      wr(incl_ctrl_pkg::ADDR_AVERAGE, 8'h03);
      check("avg value", 16'h0003, 16'(avg_log2_o));
   endtask : t_avg

   task automatic t_misc;
      int n;
      for (int k = 0; k < 2; k++) begin
         wr(incl_ctrl_pkg::ADDR_MISC, k ? 8'h06 : 8'h05);
         check("line two enable", 16'(k == 0), 16'(io_line_two_oe_o));
         check("line one enable", 16'(k == 1), 16'(io_line_one_oe_o));
         wait_strobe(n);
         n = 0;
         // One whole period of 30 cycles, whatever the phase
         for (int c = 0; c < 30; c++) begin
            @(negedge clk_i);
            if ((k ? io_line_one_o : ~io_line_two_o) === 1'b1) n++;
         end
         check("active cycles", 16'h0001, 16'(n >= 7 && n <= 8));
      end
      wr(incl_ctrl_pkg::ADDR_MISC + 7'h01, 8'h05);
      check("self_test_o on", 16'h0001, 16'(self_test_o));
      check("power_on_test_en_o off", 16'h0000, 16'(power_on_test_en_o));
      wr(incl_ctrl_pkg::ADDR_MISC + 7'h01, 8'h00);
      check("self_test_o off", 16'h0000, 16'(self_test_o));
      wr(incl_ctrl_pkg::ADDR_MISC, 8'h00);
      check("enables off", 16'h0000, 16'({io_line_one_oe_o, io_line_two_oe_o}));
   endtask : t_misc

   task automatic t_sleep;
      int n;
      slp_n = 0;
      wr(incl_ctrl_pkg::ADDR_SLEEP, 8'h02);
      wr(incl_ctrl_pkg::ADDR_SLEEP, 8'h05);
      n = 0;
      while (sleep_o !== 1'b0 && n < 1000) begin
         @(negedge clk_i);
         n++;
      end
      check("sleep cycles", 16'h00C8, 16'(slp_n));
      wr(incl_ctrl_pkg::ADDR_SLEEP, 8'h03);
      check("sleep started", 16'h0001, 16'(sleep_o));
      rst_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      // Look after release so a resumed sleep would show
      repeat (2) @(negedge clk_i);
      check("sleep after reset", 16'h0000, 16'(sleep_o));
      check("avg after reset", 16'h0008, 16'(avg_log2_o));
   endtask : t_sleep

   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   initial begin
      rst_n_i = 1'b0;
      supply_sample_i = 14'h0000;
      aux_sample_i = 12'h000;
      status_nonzero_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_reset();
      t_period();
      t_read();
      t_avg();
      t_misc();
      t_sleep();
      stop_test();
   end

   initial begin
      #300000;
      n_mismatch++;
      stop_test();
   end
endmodule : incl_ctrl_tb
